// file: rtl/oqt_consts.svh
`ifndef OQT_CONSTS_SVH
`define OQT_CONSTS_SVH

// Register offsets
`define OQT_ADDR_LINE_ACTIVE_SELECT    12'h00C
`define OQT_ADDR_MARK      12'h101
`define OQT_ADDR_NIBBLES   12'h105
`define OQT_ADDR_STATUS    12'h106
`define OQT_ADDR_CMD_BASE  12'h110
`define OQT_ADDR_CMD_LAST  12'h11F

// Field positions
`define OQT_BIT_LINE_ACTIVE_SELECT     7
`define OQT_MARK_LSB       4
`define OQT_RELEASE_LSB    4
`define OQT_HALT_LSB       0
`define OQT_BIT_QF         4
`define OQT_BIT_MNF        1
`define OQT_BIT_MF         0
`define OQT_CMD_ENABLE     1
`define OQT_CMD_SELECT     0

// Reset values
`define OQT_RESET_BYTE     8'h00
`define OQT_RESET_LINE_ACTIVE_SELECT   1'b0

// Thresholds in cells below the queue limit
`define OQT_MARK_ON_GAP    27
`define OQT_MARK_OFF_GAP   54
`define OQT_DISCARD_GAP    27

// Cell layout
`define OQT_CELL_BYTES     6'h35
`define OQT_PT_BYTE        6'h03
`define OQT_EFCI_BIT       2
`define OQT_BEST_EFFORT    2'h3

`endif

// file: rtl/oqt_pkg.sv
package oqt_pkg;

  // Service classes, in queue order
  typedef enum logic [1:0] {
    oqt_class_cbr,
    oqt_class_vbr_rt,
    oqt_class_vbr_nrt,
    oqt_class_best_effort
  } oqt_class_type;

  // Outlet transfer state
  typedef enum logic {
    oqt_outlet_idle,
    oqt_outlet_in_cell
  } oqt_outlet_state_type;

endpackage : oqt_pkg

// file: rtl/oqt_cell_outlet.sv
`timescale 1ns/1ps
`include "oqt_consts.svh"

module oqt_cell_outlet
  import oqt_pkg::*;
(
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // Link timing and line control
  input  wire logic       link_rise,
  input  wire logic       line_active_select,
  // Cell byte source
  input  wire logic       src_valid,
  input  wire logic [7:0] src_byte,
  input  wire logic       src_soc,
  // Header patching
  input  wire logic       gfc_en,
  input  wire logic [3:0] gfc_nib,
  input  wire logic       efci_en,
  output logic            take,
  output logic            take_first,
  // Outlet pins
  output logic [7:0]      tx_data,
  output logic            tx_soc,
  output logic            tx_oe
);

  oqt_outlet_state_type state, next_state;
  logic [5:0]           byte_cnt, next_byte_cnt;
  logic [7:0]           next_tx_data;
  logic                 next_tx_soc, next_tx_oe;
  logic [7:0]           patched;

  ////////////////////////////////////////////////////////////////////////////
  // A cell only starts while line_active_select; once started it always runs to its end
  assign take_first = link_rise & src_valid & src_soc & line_active_select & (state == oqt_outlet_idle);
  assign take       = take_first | (link_rise & src_valid & (state == oqt_outlet_in_cell));

  // Header patching of the flow-control nibble and congestion bit
  always_comb begin
    patched = src_byte;
    if (take_first && gfc_en) begin
      patched = {gfc_nib, src_byte[3:0]};
    end else if (byte_cnt == `OQT_PT_BYTE && efci_en) begin
      patched[`OQT_EFCI_BIT] = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transfer state and pin drive
  always_comb begin
    next_state    = state;
    next_byte_cnt = byte_cnt;
    next_tx_data  = tx_data;
    next_tx_soc   = tx_soc;
    next_tx_oe    = tx_oe | line_active_select;
    if (take) begin
      next_tx_data  = patched;
      next_tx_soc   = take_first;
      next_tx_oe    = 1'b1;
      next_byte_cnt = take_first ? 6'h01 : byte_cnt + 6'h01;
      next_state    = (next_byte_cnt == `OQT_CELL_BYTES) ? oqt_outlet_idle : oqt_outlet_in_cell;
    end else if (link_rise) begin
      next_tx_soc = 1'b0;
      // Floats only between cells, so a cut mid-cell never truncates it
      next_tx_oe  = line_active_select | (state == oqt_outlet_in_cell);
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state    <= oqt_outlet_idle;
      byte_cnt <= 6'h00;
      tx_data  <= 8'h00;
      tx_soc   <= 1'b0;
      tx_oe    <= 1'b0;
    end else begin
      state    <= next_state;
      byte_cnt <= next_byte_cnt;
      tx_data  <= next_tx_data;
      tx_soc   <= next_tx_soc;
      tx_oe    <= next_tx_oe;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_offline_float: assert property (@(posedge clock) disable iff (rst)
    (link_rise && !line_active_select && !take && state == oqt_outlet_idle) |=> !tx_oe)
    else $error("outlet pins still driven while offline");
  a_cell_finish: assert property (@(posedge clock) disable iff (rst)
    (state == oqt_outlet_in_cell) |-> tx_oe)
    else $error("outlet pins floated during a cell");
  c_offline_mid_cell: cover property (@(posedge clock) disable iff (rst)
    state == oqt_outlet_in_cell && !line_active_select && take);

endmodule : oqt_cell_outlet

// file: rtl/oqt_traffic_mgmt.sv
// How it works
// - With a port's command enable bit set, the chosen nibble is caught at the first header byte and put into the next cell.
// - Command bit 0 picks the release-value nibble when 1 and the halt-value nibble when 0.
// - Each of the 64 ports has its own two-bit command, packed four to a register over sixteen registers.
// - A user cell gets its congestion bit set when its class enable is on and its queue is within 27 cells of the limit.
// - The four class enables sit in bits 7 to 4 of one register, constant-rate class lowest.
// - Marking stops when the class enable clears, the queue empties, or the fill drops to 54 below the limit.
// - With packet discard on, a best-effort queue enters discard when its fill exceeds the limit minus 27.
// - A queue in discard takes only end-of-message cells and drops the rest.
// - Discard ends once the fill falls to half the limit.
// - The queue-full flag rises when a write brings a queue to its limit.
// - The space-free flag rises when a read leaves room for another cell.
// - The memory-full flag rises when a write fills the whole buffer.
// - A queue at its limit drops all arrivals, and a full buffer drops arrivals for every queue.
// - While offline the outlet pins float and the inlet data is ignored.
// - Going offline mid-cell lets the cell finish before the pins float.
`timescale 1ns/1ps
`include "oqt_consts.svh"

module oqt_traffic_mgmt
  import oqt_pkg::*;
#(
  parameter int QUEUE_LIMIT = 128,
  parameter int MEM_CELLS   = 256,
  parameter int FILL_W      = $clog2(QUEUE_LIMIT + 1),
  parameter int MEM_W       = $clog2(MEM_CELLS + 1)
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // Register port
  input  wire logic [11:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic [7:0]       reg_rdata,
  input  wire logic        packet_discard_enable,
  // Queue events
  input  wire logic        enq_valid,
  input  wire logic [1:0]  enq_class,
  input  wire logic        enq_eom,
  input  wire logic        deq_valid,
  input  wire logic [1:0]  deq_class,
  output logic             enq_taken,
  output logic             enq_dropped,
  // Outlet cell source
  input  wire logic        src_valid,
  input  wire logic [7:0]  src_byte,
  input  wire logic        src_soc,
  input  wire logic [5:0]  src_port,
  input  wire logic [1:0]  src_class,
  input  wire logic        src_user,
  output logic             src_ready,
  // Link pins
  input  wire logic        link_clk,
  output logic [7:0]       tx_data,
  output logic             tx_soc,
  output logic             tx_oe,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_soc,
  input  wire logic        rx_valid,
  // Inlet bytes toward the core
  output logic [7:0]       cell_byte,
  output logic             cell_soc,
  output logic             cell_valid
);

  localparam logic [FILL_W-1:0] LIMIT    = FILL_W'(QUEUE_LIMIT);
  localparam logic [FILL_W-1:0] MARK_ON  = FILL_W'(QUEUE_LIMIT - `OQT_MARK_ON_GAP);
  localparam logic [FILL_W-1:0] MARK_OFF = FILL_W'(QUEUE_LIMIT - `OQT_MARK_OFF_GAP);
  localparam logic [FILL_W-1:0] PD_ON    = FILL_W'(QUEUE_LIMIT - `OQT_DISCARD_GAP);
  localparam logic [FILL_W-1:0] PD_OFF   = FILL_W'(QUEUE_LIMIT / 2);
  localparam logic [MEM_W-1:0]  MEM_TOP  = MEM_W'(MEM_CELLS);

  // All checks, per-queue ones too, share the system clock and reset
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////
  // Link pin synchronisers; stage 1 feeds stage 2 only
  logic [2:0] link_sync;
  logic [7:0] rx_data_s1, rx_data_s2;
  logic       rx_soc_s1, rx_soc_s2, rx_valid_s1, rx_valid_s2;
  logic       link_rise;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      link_sync   <= 3'h0;
      rx_data_s1  <= 8'h00;
      rx_data_s2  <= 8'h00;
      rx_soc_s1   <= 1'b0;
      rx_soc_s2   <= 1'b0;
      rx_valid_s1 <= 1'b0;
      rx_valid_s2 <= 1'b0;
    end else begin
      link_sync   <= {link_sync[1:0], link_clk};
      rx_data_s1  <= rx_data;
      rx_data_s2  <= rx_data_s1;
      rx_soc_s1   <= rx_soc;
      rx_soc_s2   <= rx_soc_s1;
      rx_valid_s1 <= rx_valid;
      rx_valid_s2 <= rx_valid_s1;
    end
  end

  assign link_rise = link_sync[1] & ~link_sync[2];

  ////////////////////////////////////////////////////////////////////////////
  // Software registers
  logic       line_active_select, next_line_active_select;
  logic [7:0] mark_en, next_mark_en;
  logic [7:0] nibbles, next_nibbles;
  logic [7:0] cmd_reg [16];
  logic [7:0] next_cmd [16];
  logic       pd_en, next_pd_en;

  always_comb begin
    next_line_active_select  = line_active_select;
    next_mark_en = mark_en;
    next_nibbles = nibbles;
    next_cmd     = cmd_reg;
    next_pd_en   = packet_discard_enable;
    if (reg_write) begin
      if (reg_addr == `OQT_ADDR_LINE_ACTIVE_SELECT) begin
        next_line_active_select = reg_wdata[`OQT_BIT_LINE_ACTIVE_SELECT];
      end else if (reg_addr == `OQT_ADDR_MARK) begin
        next_mark_en = reg_wdata;
      end else if (reg_addr == `OQT_ADDR_NIBBLES) begin
        next_nibbles = reg_wdata;
      end else if (reg_addr >= `OQT_ADDR_CMD_BASE && reg_addr <= `OQT_ADDR_CMD_LAST) begin
        next_cmd[reg_addr[3:0]] = reg_wdata;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      line_active_select  <= `OQT_RESET_LINE_ACTIVE_SELECT;
      mark_en <= `OQT_RESET_BYTE;
      nibbles <= `OQT_RESET_BYTE;
      cmd_reg <= '{default: `OQT_RESET_BYTE};
      pd_en   <= 1'b0;
    end else begin
      line_active_select  <= next_line_active_select;
      mark_en <= next_mark_en;
      nibbles <= next_nibbles;
      cmd_reg <= next_cmd;
      pd_en   <= next_pd_en;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-class queue accounting
  logic [FILL_W-1:0] fill [4];
  logic [3:0]        mark, pd, accept_q, deq_q, qf_q;
  logic [MEM_W-1:0]  mem_total, next_mem_total;
  logic              mem_full, accept_any, deq_any;

  assign mem_full = (mem_total == MEM_TOP);

  for (genvar q = 0; q < 4; q++) begin : g_queue
    logic [FILL_W-1:0] next_fill;
    logic              next_mark, next_pd, drop;

    always_comb begin
      // A full queue or full buffer drops without looking at the cell
      drop        = mem_full || fill[q] == LIMIT;
      if (q == `OQT_BEST_EFFORT && pd[q] && !enq_eom) begin
        drop = 1'b1;
      end
      accept_q[q] = enq_valid && enq_class == 2'(q) && !drop;
      deq_q[q]    = deq_valid && deq_class == 2'(q) && fill[q] != '0;
      next_fill   = fill[q];
      if (accept_q[q] && !deq_q[q]) begin
        next_fill = fill[q] + FILL_W'(1);
      end else if (deq_q[q] && !accept_q[q]) begin
        next_fill = fill[q] - FILL_W'(1);
      end
      qf_q[q] = accept_q[q] && next_fill == LIMIT;
      // Hysteresis keeps marking steady between the two levels
      next_mark = mark[q];
      if (!next_mark_en[`OQT_MARK_LSB + q] || next_fill == '0 || next_fill <= MARK_OFF) begin
        next_mark = 1'b0;
      end else if (next_fill >= MARK_ON) begin
        next_mark = 1'b1;
      end
      next_pd = pd[q];
      if (q != `OQT_BEST_EFFORT || !next_pd_en || next_fill <= PD_OFF) begin
        next_pd = 1'b0;
      end else if (next_fill > PD_ON) begin
        next_pd = 1'b1;
      end
    end

    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        fill[q] <= '0;
        mark[q] <= 1'b0;
        pd[q]   <= 1'b0;
      end else begin
        fill[q] <= next_fill;
        mark[q] <= next_mark;
        pd[q]   <= next_pd;
      end
    end

    a_mark_raise: assert property (
      (mark_en[`OQT_MARK_LSB + q] && fill[q] >= MARK_ON) |-> mark[q])
      else $error("congestion marking missing near queue limit");
    a_mark_clear: assert property (
      (!mark_en[`OQT_MARK_LSB + q] || fill[q] == '0 || fill[q] <= MARK_OFF) |-> !mark[q])
      else $error("congestion marking held past its release");
    a_fill_count: assert property (
      (accept_q[q] && !deq_q[q]) |=> fill[q] == $past(fill[q]) + FILL_W'(1))
      else $error("queue count did not follow an enqueue");
  end

  // Whole buffer occupancy
  assign accept_any = |accept_q;
  assign deq_any    = |deq_q;

  always_comb begin
    next_mem_total = mem_total;
    if (accept_any && !deq_any) begin
      next_mem_total = mem_total + MEM_W'(1);
    end else if (deq_any && !accept_any) begin
      next_mem_total = mem_total - MEM_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status flags, cleared by reading; a new event beats the clear
  logic qf, buffer_space_free_flag, mf, next_qf, next_mnf, next_mf, status_rd;
  logic enq_taken_n, enq_dropped_n;
  logic [7:0] next_rdata;

  assign status_rd = reg_read && reg_addr == `OQT_ADDR_STATUS;

  always_comb begin
    next_qf       = (|qf_q) | (qf & ~status_rd);
    next_mnf      = deq_any | (buffer_space_free_flag & ~status_rd);
    next_mf       = (accept_any && next_mem_total == MEM_TOP) | (mf & ~status_rd);
    enq_taken_n   = accept_any;
    enq_dropped_n = enq_valid && !accept_any;
    next_rdata    = reg_rdata;
    if (reg_read) begin
      next_rdata = 8'h00;
      if (reg_addr == `OQT_ADDR_LINE_ACTIVE_SELECT) begin
        next_rdata[`OQT_BIT_LINE_ACTIVE_SELECT] = line_active_select;
      end else if (reg_addr == `OQT_ADDR_MARK) begin
        next_rdata = mark_en;
      end else if (reg_addr == `OQT_ADDR_NIBBLES) begin
        next_rdata = nibbles;
      end else if (reg_addr == `OQT_ADDR_STATUS) begin
        next_rdata[`OQT_BIT_QF]  = qf;
        next_rdata[`OQT_BIT_MNF] = buffer_space_free_flag;
        next_rdata[`OQT_BIT_MF]  = mf;
      end else if (reg_addr >= `OQT_ADDR_CMD_BASE && reg_addr <= `OQT_ADDR_CMD_LAST) begin
        next_rdata = cmd_reg[reg_addr[3:0]];
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mem_total   <= '0;
      qf          <= 1'b0;
      buffer_space_free_flag         <= 1'b0;
      mf          <= 1'b0;
      reg_rdata   <= 8'h00;
      enq_taken   <= 1'b0;
      enq_dropped <= 1'b0;
    end else begin
      mem_total   <= next_mem_total;
      qf          <= next_qf;
      buffer_space_free_flag         <= next_mnf;
      mf          <= next_mf;
      reg_rdata   <= next_rdata;
      enq_taken   <= enq_taken_n;
      enq_dropped <= enq_dropped_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flow-control nibble held per port until that port's next cell
  logic [3:0]  pend_nib [64];
  logic [63:0] pend_valid, next_pend_valid;
  logic [7:0]  cmd_word;
  logic [1:0]  port_cmd;
  logic [3:0]  sel_nib;
  logic        take, take_first;

  assign cmd_word = cmd_reg[src_port[5:2]];
  assign port_cmd = cmd_word[{src_port[1:0], 1'b0} +: 2];
  assign sel_nib  = port_cmd[`OQT_CMD_SELECT] ? nibbles[`OQT_RELEASE_LSB +: 4]
                                              : nibbles[`OQT_HALT_LSB +: 4];

  always_comb begin
    next_pend_valid = pend_valid;
    if (take_first) begin
      next_pend_valid[src_port] = port_cmd[`OQT_CMD_ENABLE];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pend_valid <= 64'h0000000000000000;
      pend_nib   <= '{default: 4'h0};
      src_ready  <= 1'b0;
      cell_byte  <= 8'h00;
      cell_soc   <= 1'b0;
      cell_valid <= 1'b0;
    end else begin
      pend_valid <= next_pend_valid;
      if (take_first) begin
        pend_nib[src_port] <= sel_nib;
      end
      src_ready  <= take;
      // Inlet bytes pass only while this device owns the line
      cell_byte  <= rx_data_s2;
      cell_soc   <= rx_soc_s2;
      cell_valid <= link_rise && line_active_select && rx_valid_s2;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outlet pin driver
  oqt_cell_outlet oqt_cell_outlet_i (
    .clock      (clock),
    .rst        (rst),
    .link_rise  (link_rise),
    .line_active_select     (line_active_select),
    .src_valid  (src_valid),
    .src_byte   (src_byte),
    .src_soc    (src_soc),
    .gfc_en     (pend_valid[src_port]),
    .gfc_nib    (pend_nib[src_port]),
    .efci_en    (src_user && mark[src_class]),
    .take       (take),
    .take_first (take_first),
    .tx_data    (tx_data),
    .tx_soc     (tx_soc),
    .tx_oe      (tx_oe)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_gfc_latch: assert property ((take_first && port_cmd[`OQT_CMD_ENABLE]) |=>
    pend_valid[$past(src_port)])
    else $error("flow-control nibble not held for next cell");
  a_gfc_select: assert property ((take_first && port_cmd[`OQT_CMD_ENABLE]) |=>
    pend_nib[$past(src_port)] == ($past(port_cmd[`OQT_CMD_SELECT]) ?
      $past(nibbles[`OQT_RELEASE_LSB +: 4]) : $past(nibbles[`OQT_HALT_LSB +: 4])))
    else $error("wrong flow-control nibble chosen");
  a_pd_enter: assert property ((pd_en && fill[3] > PD_ON) |-> pd[3])
    else $error("discard state not entered");
  a_pd_drop: assert property ((enq_valid && enq_class == `OQT_BEST_EFFORT && pd[3] && !enq_eom)
    |=> enq_dropped && !enq_taken)
    else $error("non-final cell accepted during discard");
  a_pd_exit: assert property ((fill[3] <= PD_OFF) |-> !pd[3])
    else $error("discard state held at half fill");
  a_queue_full: assert property ((|qf_q) |=> qf[*2] or (qf ##1 $past(status_rd)))
    else $error("queue-full flag missed");
  a_space_flag: assert property (deq_any |=> buffer_space_free_flag)
    else $error("space-free flag missed");
  a_buffer_full: assert property ((accept_any && !deq_any && mem_total == MEM_TOP - MEM_W'(1)) |=> mf)
    else $error("memory-full flag missed");
  a_full_discard: assert property ((enq_valid && mem_full) |=> !enq_taken)
    else $error("cell accepted into a full buffer");
  a_inlet_ignored: assert property (!line_active_select |=> !cell_valid)
    else $error("inlet byte passed while offline");

  c_gfc_insert: cover property (take_first && pend_valid[src_port]);
  c_pd_drop: cover property (enq_dropped && pd[3]);
  c_queue_full: cover property (|qf_q);

endmodule : oqt_traffic_mgmt

// file: verification/oqt_link_partner.sv
`timescale 1ns/1ps

module oqt_link_partner (
  // Link clock control
  input  wire logic       run,
  output logic            link_clk,
  // Outlet pins seen from the line
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_soc,
  input  wire logic       tx_oe,
  // Inlet pins driven onto the line
  output logic [7:0]      rx_data,
  output logic            rx_soc,
  output logic            rx_valid
);
  logic [7:0] cap [0:52];
  int         idx = 0;
  int         sent = 0;

  ////////////////////////////////////////////////////////////////////////
  // Clock stands low between frames
  initial begin
    link_clk = 1'b0;
    forever begin
      #400;
      link_clk = run ? ~link_clk : 1'b0;
    end
  end

  // Sole device on this line, so it always answers; bytes count from 1, start flag every 53
  always @(posedge link_clk or negedge run) begin
    sent     = run ? sent + 1 : sent;
    rx_soc   <= run && (sent % 53 == 1);
    rx_valid <= run;
    rx_data  <= run ? 8'(sent) : ~8'(sent); // Released bus shows the inverse
  end

  // Sample mid period; only the 53 bytes from a start flag, idle line time is skipped
  always @(negedge link_clk) begin
    if (tx_oe === 1'b1 && (tx_soc === 1'b1 || (idx > 0 && idx < 53))) begin
      if (tx_soc === 1'b1) begin
        idx = 0;
      end
      cap[idx % 53] = tx_data;
      idx++;
    end
  end
endmodule : oqt_link_partner

// file: verification/outlet_queue_traffic_mgmt_test.sv
`timescale 1ns/1ps
`include "oqt_consts.svh"

module outlet_queue_traffic_mgmt_test;
  logic [11:0] reg_addr = 12'h000;
  logic [7:0]  reg_wdata = 8'h00, reg_rdata, src_byte = 8'h00, tx_data, rx_data, cell_byte;
  logic        clock, rst = 1'b1, reg_write = 1'b0, reg_read = 1'b0, disc_en = 1'b0;
  logic        enq_valid = 1'b0, enq_eom = 1'b0, deq_valid = 1'b0, enq_taken, enq_dropped;
  logic [1:0]  enq_class = 2'h0, deq_class = 2'h0, src_class = 2'h0;
  logic        src_valid = 1'b0, src_soc = 1'b0, src_user = 1'b0, src_ready;
  logic [5:0]  src_port = 6'h00;
  logic        link_clk, link_run = 1'b0, tx_soc, tx_oe, rx_soc, rx_valid, cell_soc, cell_valid;
  int          fail_count = 0, total_checks = 0, rx_seen = 0;

  // Small limits keep fills short: marking at 37, discard above 37, exit at 32
  oqt_traffic_mgmt #(.QUEUE_LIMIT(64), .MEM_CELLS(100)) oqt_traffic_mgmt_i (
    .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .packet_discard_enable(disc_en),
    .enq_valid(enq_valid), .enq_class(enq_class), .enq_eom(enq_eom), .deq_valid(deq_valid),
    .deq_class(deq_class), .enq_taken(enq_taken), .enq_dropped(enq_dropped),
    .src_valid(src_valid), .src_byte(src_byte), .src_soc(src_soc), .src_port(src_port),
    .src_class(src_class), .src_user(src_user), .src_ready(src_ready), .link_clk(link_clk),
    .tx_data(tx_data), .tx_soc(tx_soc), .tx_oe(tx_oe), .rx_data(rx_data), .rx_soc(rx_soc),
    .rx_valid(rx_valid), .cell_byte(cell_byte), .cell_soc(cell_soc), .cell_valid(cell_valid));

  oqt_link_partner oqt_link_partner_i (
    .run(link_run), .link_clk(link_clk), .tx_data(tx_data), .tx_soc(tx_soc), .tx_oe(tx_oe),
    .rx_data(rx_data), .rx_soc(rx_soc), .rx_valid(rx_valid));

  ////////////////////////////////////////////////////////////////////////
  // Clock and inlet byte counter
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // Inlet watched off the launching edge; partner bytes count up from 1
  always @(negedge clock) begin
    if (cell_valid === 1'b1) begin
      check("cell byte", 8'(rx_seen + 1), cell_byte);
      check("cell soc", {7'h00, rx_seen % 53 == 0}, {7'h00, cell_soc});
      rx_seen++;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Shared tasks, all entered at a falling edge
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic reg_wr(input logic [11:0] a, input logic [7:0] d);
    reg_addr  = a;
    reg_wdata = d;
    reg_write = 1'b1;
    @(negedge clock);
    reg_write = 1'b0;
    @(negedge clock);
  endtask : reg_wr

  task automatic reg_rd(input logic [11:0] a, input logic [7:0] exp, input string what);
    reg_addr = a;
    reg_read = 1'b1;
    @(negedge clock);
    reg_read = 1'b0;
    check(what, exp, reg_rdata);
    @(negedge clock);
  endtask : reg_rd

  // Answer is a one-cycle pulse, so both candidate cycles are sampled
  task automatic enq(input logic [1:0] c, input logic e, input logic t);
    logic tk;
    logic dr;
    enq_class = c;
    enq_eom   = e;
    enq_valid = 1'b1;
    @(negedge clock);
    enq_valid = 1'b0;
    tk = enq_taken;
    dr = enq_dropped;
    @(negedge clock);
    tk = tk | enq_taken;
    dr = dr | enq_dropped;
    check("enq answer", {6'h00, t, ~t}, {6'h00, tk, dr});
  endtask : enq

  task automatic deq(input logic [1:0] c);
    deq_class = c;
    deq_valid = 1'b1;
    @(negedge clock);
    deq_valid = 1'b0;
    @(negedge clock);
  endtask : deq

  // Byte held until taken; optional offline write in mid-cell
  task automatic send_cell(input logic [1:0] c, input int off_at, input logic [7:0] b0, input logic [7:0] b3);
    int n;
    src_port  = 6'h05;
    src_class = c;
    src_user  = 1'b1;
    for (int i = 0; i < `OQT_CELL_BYTES; i++) begin
      src_byte  = (i == 0) ? 8'h03 : (i == 3) ? 8'h00 : 8'(i);
      src_soc   = (i == 0);
      src_valid = 1'b1;
      n = 0;
      @(negedge clock);
      while (src_ready !== 1'b1) begin
        n++;
        if (n > 40) begin
          fail_count++;
          final_report();
        end
        @(negedge clock);
      end
      if (i == off_at) begin
        reg_wr(`OQT_ADDR_LINE_ACTIVE_SELECT, 8'h00);
      end
    end
    src_valid = 1'b0;
    repeat (10) @(negedge clock);
    check("cell bytes", 8'h35, 8'(oqt_link_partner_i.idx));
    check("byte0", b0, oqt_link_partner_i.cap[0]);
    check("byte3", b3, oqt_link_partner_i.cap[3]);
  endtask : send_cell

  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic regs_test;
    check("tx_oe", 8'h00, {7'h00, tx_oe});
    reg_rd(`OQT_ADDR_LINE_ACTIVE_SELECT, 8'h00, "line_active_select");
    reg_wr(`OQT_ADDR_NIBBLES, 8'hA5);
    reg_rd(`OQT_ADDR_NIBBLES, 8'hA5, "nibbles");
    for (int k = 0; k < 16; k++) reg_wr(12'h110 + 12'(k), 8'(k * 17));
    for (int k = 0; k < 16; k++) reg_rd(12'h110 + 12'(k), 8'(k * 17), "command");
    reg_wr(12'h200, 8'hFF);
    reg_rd(12'h200, 8'h00, "unmapped");
    reg_wr(`OQT_ADDR_STATUS, 8'hFF);
    reg_rd(`OQT_ADDR_STATUS, 8'h00, "status");
  endtask : regs_test

  task automatic discard_test;
    disc_en = 1'b1;
    repeat (38) enq(`OQT_BEST_EFFORT, 1'b0, 1'b1);
    enq(`OQT_BEST_EFFORT, 1'b0, 1'b0);
    enq(`OQT_BEST_EFFORT, 1'b1, 1'b1);
    repeat (6) deq(`OQT_BEST_EFFORT);
    enq(`OQT_BEST_EFFORT, 1'b0, 1'b0);
    deq(`OQT_BEST_EFFORT);
    enq(`OQT_BEST_EFFORT, 1'b0, 1'b1);
  endtask : discard_test

  // Best-effort holds 33, so 64 plus 3 more fill the 100-cell buffer
  task automatic limits_test;
    reg_rd(`OQT_ADDR_STATUS, 8'h02, "status");
    repeat (64) enq(2'h2, 1'b0, 1'b1);
    enq(2'h2, 1'b0, 1'b0);
    reg_rd(`OQT_ADDR_STATUS, 8'h10, "status");
    repeat (3) enq(2'h1, 1'b0, 1'b1);
    enq(2'h0, 1'b0, 1'b0);
    reg_rd(`OQT_ADDR_STATUS, 8'h01, "status");
    deq(2'h2);
    reg_rd(`OQT_ADDR_STATUS, 8'h02, "status");
  endtask : limits_test

  task automatic outlet_test;
    int mark;
    reg_wr(`OQT_ADDR_LINE_ACTIVE_SELECT, 8'h80);
    reg_wr(`OQT_ADDR_MARK, 8'h40);
    reg_wr(12'h111, 8'h0C);
    link_run = 1'b1;
    send_cell(2'h2, 99, 8'h03, 8'h04);
    reg_wr(12'h111, 8'h08);
    send_cell(2'h0, 99, 8'hA3, 8'h00);
    reg_wr(`OQT_ADDR_MARK, 8'h00);
    check("inlet seen", 8'h01, {7'h00, rx_seen > 0});
    send_cell(2'h2, 10, 8'h53, 8'h00);
    mark = rx_seen;
    repeat (40) @(negedge clock);
    check("tx_oe", 8'h00, {7'h00, tx_oe});
    check("inlet offline", 8'h00, 8'(rx_seen - mark));
    link_run = 1'b0;
  endtask : outlet_test

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (5) @(negedge clock);
    rst = 1'b0;
    @(negedge clock);
    regs_test();
    discard_test();
    limits_test();
    outlet_test();
    final_report();
  end
endmodule : outlet_queue_traffic_mgmt_test
